// ===== verif/toa_host.sv
`default_nettype none
module toa_host #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter int HALF = 8
) (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock line stands high and data released between frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // wait n falling edges of the system clock
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask : tick
  // data changes mid low phase, line sampled at end of high phase
  task automatic bit_io(input logic b, output logic s);
    tick(HALF / 2);
    sda_low_out = ~b;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    s = sda_in;
    scl_out = 1'b0;
  endtask : bit_io
  // start or repeated start
  task automatic start_c;
    tick(HALF / 2);
    sda_low_out = 1'b0;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask : start_c
  task automatic stop_c;
    tick(HALF / 2);
    sda_low_out = 1'b1;
    tick(HALF / 2);
    scl_out = 1'b1;
    tick(HALF);
    sda_low_out = 1'b0;
    tick(HALF);
  endtask : stop_c
  // one byte plus its acknowledge slot
  task automatic byte_io(input logic [7:0] d, input logic ack_b, output logic [7:0] q,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_b, a);
  endtask : byte_io
  // write byte transfer
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_c();
    byte_io({ADDR, 1'b0}, 1'b1, q, a0);
    byte_io(cmd, 1'b1, q, a1);
    byte_io(d, 1'b1, q, a2);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask : wr
  // read byte transfer, ended by a master nack
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, nk;
    start_c();
    byte_io({ADDR, 1'b0}, 1'b1, q, a0);
    byte_io(cmd, 1'b1, q, a1);
    start_c();
    byte_io({ADDR, 1'b1}, 1'b1, q, a2);
    byte_io(8'hFF, 1'b1, d, nk);
    stop_c();
    ok = !(a0 | a1 | a2);
  endtask : rd
endmodule : toa_host
`default_nettype wire

// ===== verif/toa_regs_tb.sv
`default_nettype none
module toa_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import toa_pkg::*;
  logic clock_in, rst_n_in, scl, sda_low, sda_oe, sda_o, al_o, alarm_oe, tmo_en, ok, sda_w;
  logic [7:0] cfg_o, q, rl, ll, mk, r, l, st, c;
  logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h6E, 8'h50, 8'h00, 8'h00, 8'h00};
  toa_meas_t meas;
  int errors, compares;
  // open-drain data line with pull-up
  assign sda_w = ~(sda_low | sda_oe);
  toa_regs #(.SLAVE_ADDR(7'h2A), .TIMEOUT_CYC(64)) dut (.clock_in(clock_in),
    .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .meas_in(meas), .overtemp_alarm_n_out(al_o), .overtemp_alarm_n_oe_out(alarm_oe),
    .config_out(cfg_o), .timeout_en_out(tmo_en));
  toa_host #(.ADDR(7'h2A), .HALF(8)) host (.clock_in(clock_in), .sda_in(sda_w),
    .scl_out(scl), .sda_low_out(sda_low));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // expected status from values and limits
  function automatic logic [7:0] exp_st(input logic [7:0] rv, lv, rlim, llim);
    return {rv > rlim, lv > llim, 6'h00};
  endfunction : exp_st
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, q, ok);
    chk({7'h00, ok}, 8'h01, "read ack");
    chk(q, e, "read data");
  endtask : rchk
  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    chk({7'h00, ok}, 8'h01, "write ack");
  endtask : wchk
  // one-cycle measurement pulse
  task automatic measure(input logic [7:0] rv, input logic [7:0] lv);
    @(negedge clock_in);
    meas = {1'b1, rv, lv};
    @(negedge clock_in);
    meas.valid = 1'b0;
    @(negedge clock_in);
  endtask : measure
  task automatic chk_alarm(input logic e);
    chk({7'h00, alarm_oe}, {7'h00, e}, "alarm");
  endtask : chk_alarm
  // watchdog
  initial begin
    // the full run needs about 58000 cycles
    repeat (80000) @(posedge clock_in);
    errors++;
    $display("CHECK FAILED %0t timeout", $time);
    finish_test();
  end
  initial begin
    rst_n_in = 1'b0;
    meas = '0;
    errors = 0;
    compares = 0;
    void'($urandom(32'hAC82570C));
    repeat (3) @(negedge clock_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clock_in);
    chk({alarm_oe, tmo_en, cfg_o[5:0]}, 8'h40, "reset pins");
    chk({6'h00, sda_o, al_o}, 8'h00, "pin drive levels");
    for (int i = 0; i < 8; i++) rchk(8'(i), rst_v[i]);
    // lockup timeout: hold the clock low while the block drives a zero bit
    host.start_c();
    host.byte_io({7'h2A, 1'b1}, 1'b1, q, ok);
    chk({7'h00, ok}, 8'h00, "lockup addr ack");
    repeat (8) @(negedge clock_in);
    chk({7'h00, sda_oe}, 8'h01, "data bit driven");
    repeat (80) @(negedge clock_in);
    chk({7'h00, sda_oe}, 8'h00, "lockup release");
    host.stop_c();
    // configuration with timeout bit both ways
    for (int k = 0; k < 2; k++) begin
      c = {2'($urandom), k[0], 5'($urandom)};
      wchk(8'h02, c);
      rchk(8'h02, c);
      chk(cfg_o, c, "cfg out");
      chk({7'h00, tmo_en}, {7'h00, ~k[0]}, "timeout en");
    end
    wchk(8'h00, 8'hA5);
    wchk(8'h05, 8'hC0);
    rchk(8'h00, 8'h00);
    rchk(8'h05, 8'h00);
    rl = 8'h6E;
    ll = 8'h50;
    for (int n = 0; n < 7; n++) begin
      if (n == 0) {r, l, mk} = {rl, ll, 8'h00};
      else if (n == 1) {r, l, mk} = {rl + 8'h01, ll + 8'h01, 8'h00};
      else if (n == 2) {r, l, mk} = {8'hFF, 8'hFF, 8'hC0};
      else begin
        rl = 8'($urandom);
        ll = 8'($urandom);
        wchk(8'h03, rl);
        wchk(8'h04, ll);
        {r, l, mk} = {8'($urandom), 8'($urandom), 2'($urandom), 6'h00};
      end
      wchk(8'h06, mk);
      measure(r, l);
      st = exp_st(r, l, rl, ll);
      chk_alarm(|(st & ~mk));
      rchk(8'h00, r);
      rchk(8'h01, l);
      rchk(8'h03, rl);
      rchk(8'h04, ll);
      rchk(8'h06, mk);
      rchk(8'h05, st);
      chk_alarm(1'b0);
      rchk(8'h05, 8'h00);
      rchk(8'h01, l);
      measure(r, l);
      chk_alarm(|(st & ~mk));
      rchk(8'h05, st);
    end
    finish_test();
  end
endmodule : toa_regs_tb
`default_nettype wire

// ===== verilog/toa_cfg.svh
`ifndef TOA_CFG_SVH
`define TOA_CFG_SVH

// register offsets
`define TOA_OFS_RTEMP 8'h00
`define TOA_OFS_LTEMP 8'h01
`define TOA_OFS_CFG 8'h02
`define TOA_OFS_RLIM 8'h03
`define TOA_OFS_LLIM 8'h04
`define TOA_OFS_STATUS 8'h05
`define TOA_OFS_MASK 8'h06

// reset values
`define TOA_RST_TEMP 8'h00
`define TOA_RST_CFG 8'h00
`define TOA_RST_RLIM 8'h6E
`define TOA_RST_LLIM 8'h50
`define TOA_RST_STATUS 8'h00
`define TOA_RST_MASK 8'h00
`define TOA_RD_NONE 8'h00

// field positions
`define TOA_BIT_REMOTE 7
`define TOA_BIT_LOCAL 6
`define TOA_BIT_TIMEOUT_DIS 5
`define TOA_FLAG_MASK 8'hC0

// serial byte framing
`define TOA_BIT_LAST 4'h7
`define TOA_BIT_ACK 4'h8
`define TOA_BIT_END 4'h9
`define TOA_CNT_ZERO 4'h0
`define TOA_CNT_ONE 4'h1

// bus lockup timeout, least figure
`define TOA_CLK_MHZ 50
`define TOA_TIMEOUT_US 25000
`define TOA_TMO_W 24
`define TOA_ADDR_DEF 7'h2A

`endif

// ===== verilog/toa_pkg.sv
`default_nettype none
package toa_pkg;

  // byte phase of the serial slave
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_CMD, PH_WDATA, PH_RDATA, PH_SKIP
  } toa_phase_t;

  // one measurement result from the converter
  typedef struct packed {
    logic valid;
    logic [7:0] remote;
    logic [7:0] local_t;
  } toa_meas_t;

  // whole state of the register block
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    toa_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic sda_oe;
    logic [23:0] tmo_cnt;
    logic [7:0] rtemp;
    logic [7:0] ltemp;
    logic [7:0] cfg;
    logic [7:0] rlim;
    logic [7:0] llim;
    logic [7:0] status;
    logic [7:0] mask;
    logic alarm;
  } toa_state_t;

endpackage : toa_pkg
`default_nettype wire

// ===== verilog/toa_regs.sv
// Operation
// - each temperature held as 8-bit readable register
// - 00h remote temperature, 01h local temperature
// - unsigned binary, MSB 128 C, LSB 1 C
// - read bytes shift out MSB first
// - temperature registers read zero after reset
// - configuration steers timeout, resets to zero
// - unmasked channel above limit drives alarm low
// - limits reset to 6Eh and 50h
// - status D7 remote fault, D6 local fault
// - status bits clear only by status read
// - status read releases the alarm output
// - persisting fault sets status and alarm again
// - status register reads zero after reset
// - mask 06h bits D7, D6 suppress alarm
// - configuration bit 5 one disables timeout
`include "toa_cfg.svh"
`default_nettype none
module toa_regs #(
  parameter logic [6:0] SLAVE_ADDR = `TOA_ADDR_DEF,
  parameter int unsigned TIMEOUT_CYC = `TOA_TIMEOUT_US * `TOA_CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire toa_pkg::toa_meas_t meas_in,
  output logic overtemp_alarm_n_out,
  output logic overtemp_alarm_n_oe_out,
  output logic [7:0] config_out,
  output logic timeout_en_out
);
  import toa_pkg::*;

  localparam logic [`TOA_TMO_W-1:0] TMO_LAST = `TOA_TMO_W'(TIMEOUT_CYC - 1);

  // state after reset
  localparam toa_state_t RST_STATE = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
    phase: PH_IDLE, cnt: `TOA_CNT_ZERO, shift: 8'h00,
    rw: 1'b0, nack: 1'b0, ptr: 8'h00, sda_oe: 1'b0,
    tmo_cnt: '0,
    rtemp: `TOA_RST_TEMP, ltemp: `TOA_RST_TEMP, cfg: `TOA_RST_CFG,
    rlim: `TOA_RST_RLIM, llim: `TOA_RST_LLIM,
    status: `TOA_RST_STATUS, mask: `TOA_RST_MASK, alarm: 1'b0
  };

  toa_state_t r;
  toa_state_t n;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic tmo_hit;
  logic [7:0] rd_byte;
  logic [7:0] rx_byte;
  logic status_rd_done;
  logic fault_remote;
  logic fault_local;
  logic [7:0] flag_set;
  logic alarm_set;

  // line events from the synchronised pins
  assign scl_rise = r.scl_s2 & ~r.scl_d;
  assign scl_fall = ~r.scl_s2 & r.scl_d;
  assign bus_start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
  assign bus_stop = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
  assign rx_byte = {r.shift[6:0], r.sda_s2};
  assign tmo_hit = (r.tmo_cnt >= TMO_LAST);

  // over-temperature compare on the incoming result, in the cycle it is stored
  assign fault_remote = meas_in.valid && (meas_in.remote > r.rlim);
  assign fault_local = meas_in.valid && (meas_in.local_t > r.llim);
  assign alarm_set = (fault_remote && !r.mask[`TOA_BIT_REMOTE])
    || (fault_local && !r.mask[`TOA_BIT_LOCAL]);

  // status flags raised by this measurement
  always_comb begin
    flag_set = 8'h00;
    flag_set[`TOA_BIT_REMOTE] = fault_remote;
    flag_set[`TOA_BIT_LOCAL] = fault_local;
  end

  // read mux over the register map
  always_comb begin
    unique case (r.ptr)
      `TOA_OFS_RTEMP: rd_byte = r.rtemp;
      `TOA_OFS_LTEMP: rd_byte = r.ltemp;
      `TOA_OFS_CFG: rd_byte = r.cfg;
      `TOA_OFS_RLIM: rd_byte = r.rlim;
      `TOA_OFS_LLIM: rd_byte = r.llim;
      `TOA_OFS_STATUS: rd_byte = r.status & `TOA_FLAG_MASK;
      `TOA_OFS_MASK: rd_byte = r.mask & `TOA_FLAG_MASK;
      default: rd_byte = `TOA_RD_NONE;
    endcase
  end

  // next state of the slave and the registers
  always_comb begin
    n = r;
    status_rd_done = 1'b0;
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_d = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_d = r.sda_s2;
    // lockup timer runs while a transfer holds the clock low
    if ((r.phase != PH_IDLE) && !r.scl_s2 && !r.cfg[`TOA_BIT_TIMEOUT_DIS]) begin
      n.tmo_cnt = r.tmo_cnt + `TOA_TMO_W'(1);
    end else begin
      n.tmo_cnt = '0;
    end
    if (bus_start) begin
      n.phase = PH_ADDR;
      n.cnt = `TOA_CNT_ZERO;
      n.sda_oe = 1'b0;
      n.tmo_cnt = '0;
    end else if (bus_stop || tmo_hit) begin
      n.phase = PH_IDLE;
      n.cnt = `TOA_CNT_ZERO;
      n.sda_oe = 1'b0;
      n.tmo_cnt = '0;
    end else if (scl_rise) begin
      n.cnt = r.cnt + `TOA_CNT_ONE;
      unique case (r.phase)
        PH_ADDR, PH_CMD, PH_WDATA: begin
          if (r.cnt <= `TOA_BIT_LAST) begin
            n.shift = rx_byte;
          end
          if (r.cnt == `TOA_BIT_LAST) begin
            if (r.phase == PH_ADDR) begin
              if (rx_byte[7:1] == SLAVE_ADDR) begin
                n.rw = rx_byte[0];
              end else begin
                n.phase = PH_SKIP;
              end
            end else if (r.phase == PH_CMD) begin
              n.ptr = rx_byte;
            end else begin
              // writes land only in writable registers
              unique case (r.ptr)
                `TOA_OFS_CFG: n.cfg = rx_byte;
                `TOA_OFS_RLIM: n.rlim = rx_byte;
                `TOA_OFS_LLIM: n.llim = rx_byte;
                `TOA_OFS_MASK: n.mask = rx_byte & `TOA_FLAG_MASK;
                default: n.cfg = r.cfg;
              endcase
            end
          end
        end
        PH_RDATA: begin
          if (r.cnt == `TOA_BIT_ACK) begin
            n.nack = r.sda_s2;
            status_rd_done = (r.ptr == `TOA_OFS_STATUS);
          end
        end
        PH_IDLE, PH_SKIP: begin
          n.cnt = `TOA_CNT_ZERO;
        end
      endcase
    end else if (scl_fall) begin
      unique case (r.phase)
        PH_ADDR, PH_CMD, PH_WDATA: begin
          if (r.cnt == `TOA_BIT_ACK) begin
            n.sda_oe = 1'b1;
          end else if (r.cnt == `TOA_BIT_END) begin
            n.sda_oe = 1'b0;
            n.cnt = `TOA_CNT_ZERO;
            if (r.phase == PH_ADDR && r.rw) begin
              n.phase = PH_RDATA;
              n.shift = rd_byte;
              n.sda_oe = ~rd_byte[7];
            end else if (r.phase == PH_ADDR) begin
              n.phase = PH_CMD;
            end else begin
              n.phase = PH_WDATA;
            end
          end
        end
        PH_RDATA: begin
          if (r.cnt >= `TOA_CNT_ONE && r.cnt <= `TOA_BIT_LAST) begin
            n.shift = {r.shift[6:0], 1'b0};
            n.sda_oe = ~r.shift[6];
          end else if (r.cnt == `TOA_BIT_ACK) begin
            n.sda_oe = 1'b0;
          end else if (r.cnt == `TOA_BIT_END) begin
            n.cnt = `TOA_CNT_ZERO;
            if (r.nack) begin
              n.phase = PH_SKIP;
            end else begin
              n.shift = rd_byte;
              n.sda_oe = ~rd_byte[7];
            end
          end
        end
        PH_IDLE, PH_SKIP: begin
          n.sda_oe = 1'b0;
        end
      endcase
    end
    // measurement results, flags and alarm; a new fault beats a clearing read
    if (meas_in.valid) begin
      n.rtemp = meas_in.remote;
      n.ltemp = meas_in.local_t;
    end
    n.status = (status_rd_done ? 8'h00 : r.status) | flag_set;
    if (alarm_set) begin
      n.alarm = 1'b1;
    end else if (status_rd_done) begin
      n.alarm = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  // open-drain pins drive low only
  assign sda_out = 1'b0;
  assign sda_oe_out = r.sda_oe;
  assign overtemp_alarm_n_out = 1'b0;
  assign overtemp_alarm_n_oe_out = r.alarm;
  assign config_out = r.cfg;
  assign timeout_en_out = ~r.cfg[`TOA_BIT_TIMEOUT_DIS];

  // checks: reset values
  chk_temp_reset: assert property (@(posedge clock_in)
    !rst_n_in |=> (r.rtemp == `TOA_RST_TEMP) && (r.ltemp == `TOA_RST_TEMP))
    else $error("temperature not zero after reset");

  chk_cfg_reset: assert property (@(posedge clock_in)
    !rst_n_in |=> r.cfg == `TOA_RST_CFG)
    else $error("configuration not zero after reset");

  chk_limit_reset: assert property (@(posedge clock_in)
    !rst_n_in |=> (r.rlim == `TOA_RST_RLIM) && (r.llim == `TOA_RST_LLIM))
    else $error("limit reset values wrong");

  chk_status_reset: assert property (@(posedge clock_in)
    !rst_n_in |=> r.status == `TOA_RST_STATUS)
    else $error("status not zero after reset");

  chk_reset_pins: assert property (@(posedge clock_in)
    !rst_n_in |=> !sda_oe_out && !overtemp_alarm_n_oe_out && timeout_en_out)
    else $error("pins not quiet after reset");

  // checks: measurement and status
  chk_meas_store: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_in.valid |=> (r.rtemp == $past(meas_in.remote))
      && (r.ltemp == $past(meas_in.local_t)))
    else $error("measurement not stored");

  chk_temp_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !meas_in.valid |=> $stable(r.rtemp) && $stable(r.ltemp))
    else $error("temperature changed without measurement");

  chk_fault_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_in.valid && (meas_in.remote > r.rlim) |=> r.status[`TOA_BIT_REMOTE])
    else $error("remote fault flag not set");

  chk_local_flag: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_in.valid && (meas_in.local_t > r.llim) |=> r.status[`TOA_BIT_LOCAL])
    else $error("local fault flag not set");

  chk_no_fault: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    meas_in.valid && (meas_in.remote <= r.rlim) && !r.status[`TOA_BIT_REMOTE]
      |=> !r.status[`TOA_BIT_REMOTE])
    else $error("remote flag set without fault");

  chk_local_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(r.status[`TOA_BIT_LOCAL]) |-> $past(status_rd_done))
    else $error("local status cleared without status read");

  chk_flag_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    r.status[`TOA_BIT_REMOTE] && !status_rd_done |=> r.status[`TOA_BIT_REMOTE])
    else $error("remote status lost without status read");

  chk_local_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    r.status[`TOA_BIT_LOCAL] && !status_rd_done |=> r.status[`TOA_BIT_LOCAL])
    else $error("local status lost without status read");

  // checks: alarm pin, remote status clearing and status low bits
  chk_alarm_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    r.alarm && !status_rd_done |=> r.alarm)
    else $error("alarm released without status read");

  chk_mask_remote: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    fault_remote && r.mask[`TOA_BIT_REMOTE] && !r.alarm
      && !(fault_local && !r.mask[`TOA_BIT_LOCAL]) |=> !r.alarm)
    else $error("masked remote fault raised the alarm");

  chk_mask_local: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    fault_local && r.mask[`TOA_BIT_LOCAL] && !r.alarm
      && !(fault_remote && !r.mask[`TOA_BIT_REMOTE]) |=> !r.alarm)
    else $error("masked local fault raised the alarm");

  chk_alarm_cause: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(r.alarm) |-> $past(alarm_set))
    else $error("alarm raised without unmasked fault");

  chk_alarm_drive: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    alarm_set |=> overtemp_alarm_n_oe_out && !overtemp_alarm_n_out)
    else $error("alarm not driven low on fault");

  chk_alarm_release: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    status_rd_done && !alarm_set |=> !overtemp_alarm_n_oe_out)
    else $error("alarm not released by status read");

  chk_flag_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $fell(r.status[`TOA_BIT_REMOTE]) |-> $past(status_rd_done))
    else $error("status cleared without status read");

  chk_status_low: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    r.status[5:0] == 6'h00)
    else $error("status low bits not zero");

  // checks: serial bus
  chk_timeout_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    r.cfg[`TOA_BIT_TIMEOUT_DIS] |-> r.tmo_cnt == '0)
    else $error("timeout runs while disabled");

  chk_lockup_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tmo_hit && !bus_start |=> (r.phase == PH_IDLE) && !sda_oe_out)
    else $error("lockup timeout did not free the bus");

  chk_sda_idle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (r.phase == PH_IDLE) |-> !sda_oe_out)
    else $error("data line held while bus idle");

  chk_read_first: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    scl_fall && (r.phase == PH_ADDR) && r.rw && (r.cnt == `TOA_BIT_END)
      |=> sda_oe_out == !$past(rd_byte[7]))
    else $error("read byte does not start with its top bit");

endmodule : toa_regs
`default_nettype wire
